//--- bench/bus_master_model.sv
// Purpose: Bus master model on SCL and SDA
// Assumes: Bus clock of 64 ns, 16 core clocks
// Notes: Pulls SDA low only; the bench resolves the wire
`timescale 1ns/10ps
`default_nettype none

module bus_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // ==========
  // Bit and frame timing
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Data moves mid low phase so it never races an SCL edge
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    sda_low_out <= ~b;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  task automatic start();
    wt(4);
    sda_low_out <= 1'b0;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    sda_low_out <= 1'b1;
    wt(8);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    wt(4);
    sda_low_out <= 1'b1;
    wt(4);
    scl_out <= 1'b1;
    wt(8);
    sda_low_out <= 1'b0;
    wt(8);
  endtask

  task automatic put(input logic [7:0] d, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], nack);
    end
    bit_io(1'b1, nack);
  endtask

  // Ack each byte but the last so the device stops sending
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // Quarter degrees: with the sign set, drop it and take away 512
  function automatic int quarters(input logic [9:0] code);
    return code[9] ? int'(code[8:0]) - 512 : int'(code);
  endfunction
endmodule
`default_nettype wire

//--- bench/temp_sensor_conv_alert_regs_props.sv
// Purpose: Concurrent checks on the sensor core pins
// Assumes: One clock domain, reset active low
// Notes: Bound to every instance of the core
`include "temp_sensor_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module temp_sensor_props #(
  parameter int unsigned PERIOD_CYC = `TS_PERIOD_CYC,
  parameter int unsigned CONV_CYC = `TS_CONV_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [9:0] adc_code_in,
  input wire logic alert_out,
  input wire logic alert_oe_out,
  input wire logic analog_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========
  // Helper counters
  logic [31:0] on_cnt_r;
  logic [7:0] since_conv_r;
  logic [7:0] bus_quiet_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_cnt_r <= 32'h0;
      since_conv_r <= 8'hff;
      bus_quiet_r <= 8'hff;
    end else begin
      on_cnt_r <= analog_on_out ? on_cnt_r + 32'h1 : 32'h0;
      since_conv_r <= analog_on_out ? 8'h00 : since_conv_r + {7'h0, since_conv_r != 8'hff};
      bus_quiet_r <= !scl_in ? 8'h00 : bus_quiet_r + {7'h0, bus_quiet_r != 8'hff};
    end
  end

  sequence stop_seen;
    scl_in && $rose(sda_in);
  endsequence
  // ==========
  // Assertions
  chk_reset_quiet: assert property (
    $rose(rst_b_in) |-> !sda_oe_out && !alert_oe_out && !analog_on_out)
    else $error("Outputs active just after reset");
  chk_wake_holds: assert property ($rose(analog_on_out) |=> analog_on_out [*8])
    else $error("Wake dropped early");
  chk_wake_length: assert property (
    $fell(analog_on_out) |-> on_cnt_r == 32'(`TS_SETTLE_CYC + CONV_CYC))
    else $error("Settle plus conversion length wrong");
  chk_sda_moves_low: assert property (
    $changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("SDA drive changed while SCL high");
  chk_ack_stands: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
    else $error("SDA pull released too soon");
  chk_stop_release: assert property (stop_seen |=> !sda_oe_out [*8])
    else $error("SDA driven after STOP");
  chk_open_drain: assert property (!sda_out && !alert_out)
    else $error("Open-drain output driven high");
  chk_alert_cause: assert property (
    $changed(alert_oe_out) |-> since_conv_r < 8'h08 || bus_quiet_r < 8'h40)
    else $error("Alert moved with no conversion or bus write");
endmodule

bind temp_sensor_conv_alert_regs temp_sensor_props #(
  .PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)
) u_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .adc_code_in(adc_code_in), .alert_out(alert_out),
  .alert_oe_out(alert_oe_out), .analog_on_out(analog_on_out)
);
`default_nettype wire

//--- bench/test_temp_sensor_conv_alert_regs.sv
// Purpose: Self-checking bench for the sensor core
// Assumes: Short timer and conversion counts set below
// Notes: Full power-down keeps later conversions under bench control
`include "temp_sensor_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module test_temp_sensor_conv_alert_regs;
  localparam int unsigned PER = 2000;
  localparam int unsigned CONV = 50;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [9:0] adc_code_in = 10'h068;
  logic scl, sda_low, sda_oe, alert_oe, analog_on, sda_w, nk;
  logic [15:0] v;
  logic [15:0] on_run = 16'h0000;
  logic [15:0] on_len = 16'h0000;
  int miscompares = 0;
  int checks = 0;

  // Open-drain wire with a pull-up
  assign sda_w = ~(sda_low | sda_oe);
  always #2 clk_in = ~clk_in;

  // Wake length from the pin itself: a single shot rises before the write task returns
  always @(posedge clk_in) begin
    if (analog_on === 1'b1) begin
      on_run <= on_run + 16'h0001;
    end else begin
      on_run <= 16'h0000;
      if (on_run != 16'h0000) begin
        on_len <= on_run;
      end
    end
  end

  temp_sensor_conv_alert_regs #(.PERIOD_CYC(PER), .CONV_CYC(CONV)) uut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe), .adc_code_in(adc_code_in), .alert_out(), .alert_oe_out(alert_oe),
    .analog_on_out(analog_on)
  );
  bus_master_model mst (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(sda_low));
  // ==========
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("Test %s ended, %0d mismatches so far", s, miscompares);
  endtask

  task automatic wait_on(input logic lvl, input int lim, output int n);
    n = 0;
    while (analog_on !== lvl && n < lim) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    mst.start();
    mst.put({`TS_DEV_ADDR, 1'b0}, nk);
    check("addr ack", {15'h0, nk}, 16'h0000);
    mst.put(ptr, nk);
    mst.put(d, nk);
    check("data ack", {15'h0, nk}, 16'h0000);
    mst.stop();
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [15:0] val);
    mst.start();
    mst.put({`TS_DEV_ADDR, 1'b0}, nk);
    mst.put(ptr, nk);
    mst.start();
    mst.put({`TS_DEV_ADDR, 1'b1}, nk);
    mst.get(1'b0, val[15:8]);
    mst.get(1'b1, val[7:0]);
    mst.stop();
  endtask

  task automatic shot(input logic [9:0] code, input logic [7:0] cfg);
    int n;
    @(posedge clk_in);
    adc_code_in <= code;
    wr(8'h01, cfg | 8'h04);
    wait_on(1'b1, 40, n);
    wait_on(1'b0, 1100, n);
    repeat (2) @(negedge clk_in);
    check("conv length", on_len, 16'(`TS_SETTLE_CYC + CONV));
  endtask
  // ==========
  // Sequence
  initial begin
    int a;
    int b;
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    wait_on(1'b1, PER + 100, a);
    wait_on(1'b0, PER, a);
    wait_on(1'b1, PER, b);
    check("auto period", 16'(a + b), 16'(PER));
    done("auto");
    rd(8'h01, v);
    check("cfg reset", v, 16'h4040);
    rd(8'h02, v);
    check("high reset", v, 16'h7f7f);
    rd(8'h03, v);
    check("low reset", v, 16'h8080);
    wr(8'h01, 8'he0);
    wr(8'h02, 8'h19);
    wr(8'h07, 8'h14);
    rd(8'h02, v);
    check("high rw", v, 16'h1919);
    rd(8'h03, v);
    check("low alias", v, 16'h1414);
    done("registers");
    shot(10'h068, 8'he0);
    check("alert set", {15'h0, alert_oe}, 16'h0001);
    rd(8'h00, v);
    check("temp bytes", v, 16'h1a30);
    rd(8'h01, v);
    check("cfg pulses", v, 16'he0e0);
    a = 0;
    repeat (PER + 100) begin
      @(negedge clk_in);
      a += int'(analog_on === 1'b1);
    end
    check("no wake", 16'(a), 16'h0000);
    done("single shot");
    wr(8'h01, 8'he8);
    check("alert clear", {15'h0, alert_oe}, 16'h0000);
    shot(10'h068, 8'he0);
    rd(8'h00, v);
    check("temp again", v, 16'h1a30);
    shot(10'h39c, 8'he0);
    check("alert low", {15'h0, alert_oe}, 16'h0000);
    rd(8'h00, v);
    check("temp neg", v, 16'he708);
    check("neg quarters", 16'(mst.quarters(v[15:6])), 16'hff9c);
    wr(8'h01, 8'hf0);
    check("alert pol", {15'h0, alert_oe}, 16'h0001);
    done("alert");
    wr(8'h00, 8'h55);
    rd(8'h00, v);
    check("temp kept", v, 16'he700);
    wr(8'h01, 8'ha0);
    rd(8'h01, v);
    check("filter off", v, 16'ha0a0);
    shot(10'h068, 8'h80);
    check("alert off", {15'h0, alert_oe}, 16'h0000);
    rd(8'h00, v);
    check("flag no alert", v, 16'h1a10);
    mst.start();
    mst.put({`TS_DEV_ADDR ^ 7'h01, 1'b0}, nk);
    check("foreign addr", {15'h0, nk}, 16'h0001);
    mst.stop();
    done("access");
    give_verdict();
  end
endmodule
`default_nettype wire

//--- core/conv_sequencer.sv
// Purpose: Interval timer, power-up settling and conversion timing
// Assumes: single_in is a one-cycle pulse on clk_in
// Notes: A request that arrives while a conversion runs is dropped
`include "temp_sensor_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module conv_sequencer #(
  parameter int unsigned PERIOD_CYC = `TS_PERIOD_CYC,
  parameter int unsigned CONV_CYC = `TS_CONV_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic auto_en_in,
  input wire logic single_in,
  output logic powered_out,
  output logic done_out
);

  localparam logic [31:0] SETTLE_LOAD = 32'(`TS_SETTLE_CYC - 1);
  localparam logic [31:0] CONV_LOAD = 32'(CONV_CYC - 1);
  localparam logic [31:0] PERIOD_LOAD = 32'(PERIOD_CYC - 1);

  temp_sensor_pkg::seq_state_t st_r;
  logic [31:0] timer_r;
  logic [31:0] cnt_r;
  logic wake;

  // ========================================================================
  // Interval timer: the only part left running between conversions
  assign wake = auto_en_in && (timer_r == 32'h0);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_r <= PERIOD_LOAD;
    end else if (!auto_en_in || wake) begin
      timer_r <= PERIOD_LOAD;
    end else begin
      timer_r <= timer_r - 32'h1;
    end
  end

  // ========================================================================
  // Settle then convert
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= temp_sensor_pkg::SEQ_SLEEP;
      cnt_r <= 32'h0;
      powered_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (st_r)
        temp_sensor_pkg::SEQ_SLEEP: begin
          if (wake || single_in) begin
            st_r <= temp_sensor_pkg::SEQ_SETTLE;
            cnt_r <= SETTLE_LOAD;
            powered_out <= 1'b1;
          end
        end
        temp_sensor_pkg::SEQ_SETTLE: begin
          if (cnt_r == 32'h0) begin
            st_r <= temp_sensor_pkg::SEQ_CONVERT;
            cnt_r <= CONV_LOAD;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        temp_sensor_pkg::SEQ_CONVERT: begin
          if (cnt_r == 32'h0) begin
            st_r <= temp_sensor_pkg::SEQ_SLEEP;
            powered_out <= 1'b0;
            done_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        default: begin
          st_r <= temp_sensor_pkg::SEQ_SLEEP;
          powered_out <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- core/temp_sensor_cfg.svh
// Purpose: Named timing counts, register selects, field positions and resets
// Assumes: Core clock of 250 MHz
// Notes: Included by the sensor core files; definitions only
`ifndef TEMP_SENSOR_CFG_SVH
`define TEMP_SENSOR_CFG_SVH

// ==========================================================================
// Timing
`define TS_CLK_MHZ 250
`define TS_PERIOD_MS 800
`define TS_SETTLE_US 4
`define TS_CONV_US 25
`define TS_PERIOD_CYC (`TS_PERIOD_MS * 1000 * `TS_CLK_MHZ)
`define TS_SETTLE_CYC (`TS_SETTLE_US * `TS_CLK_MHZ)
`define TS_CONV_CYC (`TS_CONV_US * `TS_CLK_MHZ)

// ==========================================================================
// Serial bus
`define TS_DEV_ADDR 7'h48
`define TS_BYTE_BITS 4'h8

// ==========================================================================
// Register selects
`define TS_SEL_TEMP 2'h0
`define TS_SEL_CFG 2'h1
`define TS_SEL_HIGH 2'h2
`define TS_SEL_LOW 2'h3

// ==========================================================================
// Configuration fields and resets
`define TS_B_POWER_DOWN 7
`define TS_B_FLT 6
`define TS_B_AEN 5
`define TS_B_POL 4
`define TS_B_ACLR 3
`define TS_B_ONE 2
`define TS_CFG_RESET 8'h40
`define TS_CFG_KEEP 8'hf3
`define TS_CFG_KEEP_NOALERT 8'hc3
`define TS_TEMP_RESET 10'h000
`define TS_HIGH_RESET 8'h7f
`define TS_LOW_RESET 8'h80

`endif

//--- core/temp_sensor_conv_alert_regs.sv
// Purpose: Control logic of a standalone temperature sensor
// Assumes: SCL and SDA arrive unsynchronised; adc_code_in holds steady
//   around the end of each conversion
// Notes: Open-drain pins drive low only; the bench resolves the wires
`include "temp_sensor_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module temp_sensor_conv_alert_regs #(
  parameter int unsigned PERIOD_CYC = `TS_PERIOD_CYC,
  parameter int unsigned CONV_CYC = `TS_CONV_CYC,
  parameter logic [6:0] DEV_ADDR = `TS_DEV_ADDR,
  parameter bit HAS_ALERT = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [9:0] adc_code_in,
  output logic alert_out,
  output logic alert_oe_out,
  output logic analog_on_out
);

  // ========================================================================
  // Helpers
  function automatic logic maj3(input logic [2:0] h);
    maj3 = (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
  endfunction

  function automatic logic deg_gt(input logic [7:0] a, input logic [7:0] b);
    deg_gt = $signed(a) > $signed(b);
  endfunction

  // ========================================================================
  // Declarations
  temp_sensor_pkg::bus_state_t state_r;
  logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
  logic [9:0] adc_s1_r, adc_s2_r;
  logic [2:0] scl_h_r, sda_h_r;
  logic scl_d_r, sda_d_r;
  logic scl_f, sda_f, scl_rise, scl_fall, start_c, stop_c;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, tx_r, pointer_r, rd_data;
  logic rw_r, first_r, nack_r, byte_idx_r, sda_oe_r;
  logic wr_done, ptr_wr, reg_wr, load_rd, cfg_wr, temp_lo_rd;
  logic [7:0] cfg_r, high_r, low_r, cfg_keep;
  logic [9:0] temp_r;
  logic one_pend_r, one_go_r, alert_act_r, hi_flag_r, lo_flag_r;
  logic conv_done, above, below, alert_on, pin_low_r;

  assign cfg_keep = HAS_ALERT ? `TS_CFG_KEEP : `TS_CFG_KEEP_NOALERT;

  // ========================================================================
  // Pin synchronisers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      adc_s1_r <= `TS_TEMP_RESET;
      adc_s2_r <= `TS_TEMP_RESET;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      adc_s1_r <= adc_code_in;
      adc_s2_r <= adc_s1_r;
    end
  end

  // ========================================================================
  // Input filter: majority of three samples rejects one-cycle spikes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_h_r <= 3'h7;
      sda_h_r <= 3'h7;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_h_r <= {scl_h_r[1:0], scl_s2_r};
      sda_h_r <= {sda_h_r[1:0], sda_s2_r};
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  assign scl_f = cfg_r[`TS_B_FLT] ? maj3(scl_h_r) : scl_s2_r;
  assign sda_f = cfg_r[`TS_B_FLT] ? maj3(sda_h_r) : sda_s2_r;
  assign scl_rise = scl_f & ~scl_d_r;
  assign scl_fall = ~scl_f & scl_d_r;
  assign start_c = scl_f & scl_d_r & sda_d_r & ~sda_f;
  assign stop_c = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ========================================================================
  // Bus strobes
  assign wr_done = scl_fall && (state_r == temp_sensor_pkg::BUS_WR)
                   && (bit_cnt_r == `TS_BYTE_BITS);
  assign ptr_wr = wr_done & first_r;
  assign reg_wr = wr_done & ~first_r;
  assign cfg_wr = reg_wr && (pointer_r[1:0] == `TS_SEL_CFG);
  assign load_rd = scl_fall && (((state_r == temp_sensor_pkg::BUS_ADDR_ACK) && rw_r)
                   || ((state_r == temp_sensor_pkg::BUS_RD_ACK) && !nack_r));
  assign temp_lo_rd = load_rd && byte_idx_r && (pointer_r[1:0] == `TS_SEL_TEMP);

  // ========================================================================
  // Byte-level bus slave
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= temp_sensor_pkg::BUS_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      byte_idx_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_c) begin
      state_r <= temp_sensor_pkg::BUS_ADDR;
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop_c) begin
      state_r <= temp_sensor_pkg::BUS_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      if (scl_rise) begin
        if ((state_r == temp_sensor_pkg::BUS_ADDR) || (state_r == temp_sensor_pkg::BUS_WR)) begin
          shift_r <= {shift_r[6:0], sda_f};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (state_r == temp_sensor_pkg::BUS_RD) begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (state_r == temp_sensor_pkg::BUS_RD_ACK) begin
          nack_r <= sda_f;
        end
      end
      if (load_rd) begin
        byte_idx_r <= ~byte_idx_r;
      end
      if (scl_fall) begin
        unique case (state_r)
          temp_sensor_pkg::BUS_IDLE: begin
          end
          temp_sensor_pkg::BUS_ADDR: begin
            if (bit_cnt_r == `TS_BYTE_BITS) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                state_r <= temp_sensor_pkg::BUS_ADDR_ACK;
                sda_oe_r <= 1'b1;
                rw_r <= shift_r[0];
                first_r <= 1'b1;
              end else begin
                state_r <= temp_sensor_pkg::BUS_IDLE;
              end
            end
          end
          temp_sensor_pkg::BUS_ADDR_ACK: begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              state_r <= temp_sensor_pkg::BUS_RD;
              tx_r <= rd_data;
              sda_oe_r <= ~rd_data[7];
            end else begin
              state_r <= temp_sensor_pkg::BUS_WR;
              sda_oe_r <= 1'b0;
            end
          end
          temp_sensor_pkg::BUS_WR: begin
            if (bit_cnt_r == `TS_BYTE_BITS) begin
              state_r <= temp_sensor_pkg::BUS_WR_ACK;
              sda_oe_r <= 1'b1;
              first_r <= 1'b0;
            end
          end
          temp_sensor_pkg::BUS_WR_ACK: begin
            state_r <= temp_sensor_pkg::BUS_WR;
            sda_oe_r <= 1'b0;
            bit_cnt_r <= 4'h0;
          end
          temp_sensor_pkg::BUS_RD: begin
            if (bit_cnt_r == `TS_BYTE_BITS) begin
              state_r <= temp_sensor_pkg::BUS_RD_ACK;
              sda_oe_r <= 1'b0;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
          temp_sensor_pkg::BUS_RD_ACK: begin
            if (nack_r) begin
              state_r <= temp_sensor_pkg::BUS_IDLE;
            end else begin
              state_r <= temp_sensor_pkg::BUS_RD;
              bit_cnt_r <= 4'h0;
              tx_r <= rd_data;
              sda_oe_r <= ~rd_data[7];
            end
          end
          default: begin
            state_r <= temp_sensor_pkg::BUS_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Read data select; the pointer's upper six bits are not decoded
  always_comb begin
    unique case (pointer_r[1:0])
      `TS_SEL_TEMP: begin
        if (byte_idx_r) begin
          rd_data = {temp_r[1:0], {alert_on, hi_flag_r, lo_flag_r} & {3{HAS_ALERT}},
                     3'h0};
        end else begin
          rd_data = temp_r[9:2];
        end
      end
      `TS_SEL_CFG: rd_data = cfg_r & cfg_keep;
      `TS_SEL_HIGH: rd_data = HAS_ALERT ? high_r : 8'h00;
      `TS_SEL_LOW: rd_data = HAS_ALERT ? low_r : 8'h00;
    endcase
  end

  // ========================================================================
  // Pointer and writable registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pointer_r <= 8'h00;
      cfg_r <= `TS_CFG_RESET;
      high_r <= `TS_HIGH_RESET;
      low_r <= `TS_LOW_RESET;
    end else begin
      if (ptr_wr) begin
        pointer_r <= shift_r;
      end
      if (reg_wr && HAS_ALERT && (pointer_r[1:0] == `TS_SEL_HIGH)) begin
        high_r <= shift_r;
      end
      if (reg_wr && HAS_ALERT && (pointer_r[1:0] == `TS_SEL_LOW)) begin
        low_r <= shift_r;
      end
      if (cfg_wr) begin
        // Action bits are not stored so they read back as zero
        cfg_r <= shift_r & cfg_keep;
      end
    end
  end

  // ========================================================================
  // Single shot waits for the bus STOP so the read-back is not disturbed
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      one_pend_r <= 1'b0;
      one_go_r <= 1'b0;
    end else begin
      one_go_r <= stop_c & one_pend_r;
      if (cfg_wr && shift_r[`TS_B_ONE]) begin
        one_pend_r <= 1'b1;
      end else if (stop_c || start_c) begin
        one_pend_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Conversion scheduling
  conv_sequencer #(
    .PERIOD_CYC(PERIOD_CYC),
    .CONV_CYC(CONV_CYC)
  ) u_seq (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .auto_en_in(~cfg_r[`TS_B_POWER_DOWN]),
    .single_in(one_go_r),
    .powered_out(analog_on_out),
    .done_out(conv_done)
  );

  // ========================================================================
  // Result register; writes at select 0 never reach it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      temp_r <= `TS_TEMP_RESET;
    end else if (conv_done) begin
      temp_r <= adc_s2_r;
    end
  end

  // ========================================================================
  // Limit compare in whole degrees: drop the two fraction bits
  assign above = deg_gt(adc_s2_r[9:2], high_r);
  assign below = deg_gt(low_r, adc_s2_r[9:2]);
  assign alert_on = alert_act_r & cfg_r[`TS_B_AEN];

  // A fresh over-limit result beats a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert_act_r <= 1'b0;
      hi_flag_r <= 1'b0;
      lo_flag_r <= 1'b0;
    end else begin
      if (conv_done && above && cfg_r[`TS_B_AEN]) begin
        alert_act_r <= 1'b1;
      end else if ((cfg_wr && shift_r[`TS_B_ACLR]) || (conv_done && below)) begin
        alert_act_r <= 1'b0;
      end
      if (conv_done && above) begin
        hi_flag_r <= 1'b1;
      end else if (temp_lo_rd) begin
        hi_flag_r <= 1'b0;
      end
      if (conv_done && below) begin
        lo_flag_r <= 1'b1;
      end else if (temp_lo_rd) begin
        lo_flag_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Open-drain outputs: the pin is pulled low only, never driven high
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      alert_oe_out <= 1'b0;
      pin_low_r <= 1'b0;
    end else begin
      alert_oe_out <= HAS_ALERT & (alert_on ^ cfg_r[`TS_B_POL]);
      pin_low_r <= 1'b0;
    end
  end

  assign sda_out = pin_low_r;
  assign alert_out = pin_low_r;
  assign sda_oe_out = sda_oe_r;

endmodule
`default_nettype wire

//--- core/temp_sensor_pkg.sv
// Purpose: Types shared by the sensor core
// Assumes: Nothing
// Notes: Constants live in temp_sensor_cfg.svh
package temp_sensor_pkg;

  // ========================================================================
  // State types
  typedef enum logic [1:0] {
    SEQ_SLEEP = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_state_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ADDR_ACK = 3'b010,
    BUS_WR = 3'b011,
    BUS_WR_ACK = 3'b100,
    BUS_RD = 3'b101,
    BUS_RD_ACK = 3'b110
  } bus_state_t;

endpackage
